// ### hw/smd_decoder.sv
// Slot, ROM, I/O and DRAM strobe decoder facing the CPU bus.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "smd_map.svh"

// Behaviour
// - One wait state on every opcode fetch.
// - CPU holds while wait input low.
// - Column strobe hi-mid bank: slot 0, 8000H-BFFFH.
// - Column strobe top bank: slot 0, C000H-FFFFH.
// - Row strobe, with RAS-only refresh.
// - Address mux high for column; write enable low.
// - Low-page ROM select, internal slot 4000H-7FFFH.
// - High-page ROM select, internal slot 8000H-BFFFH.
// - Interpreter ROM select on its accesses.
// - Slot 1, 2, 3 selects by page mapping.
// - Eight slot bits from parallel port register.
// - Address bits 15,14 pick the page.
// - I/O selects from address bits 7..3, qualified.
// - Sound select active high, others low.
// - CPU pulses fetch strobe per instruction fetch.
// - CPU asserts I/O request with port address.
// - Refresh strobe with 7-bit row address.
// - Interrupt is OR of video and cartridge.
// - Reset forces every select inactive.
// - Four 16 KB pages, mapped independently.
// - Slot per page from slot register.
module smd_decoder #(
  parameter logic [3:0] FETCH_WAITS = `SMD_FETCH_WAITS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  smd_link_if.dev link,
  input wire logic i_video_irq,
  input wire logic i_cartridge_irq,
  output logic o_upper_slot_sel_n,
  output logic o_rear_slot_sel_n,
  output logic o_side_slot_sel_n,
  output logic o_interp_rom_sel_n,
  output logic o_rom_lo_page_sel_n,
  output logic o_rom_hi_page_sel_n,
  output logic o_printer_port_sel_n,
  output logic o_video_port_sel_n,
  output logic o_sound_port_sel,
  output logic o_parallel_port_sel_n,
  output logic o_dram_row_strobe_n,
  output logic o_dram_col_strobe_bank_hi_mid_n,
  output logic o_dram_col_strobe_bank_top_n,
  output logic o_dram_addr_mux_sel,
  output logic o_dram_write_en_n
);

  // Picks the two slot bits that belong to one page; bit 2p is the low one.
  function automatic logic [1:0] page_slot(input logic [7:0] bits,
                                           input logic [1:0] page);
    logic [1:0] res;
    res = 2'h0;
    case (page)
      `SMD_PAGE_0: res = {bits[1], bits[0]};
      `SMD_PAGE_1: res = {bits[3], bits[2]};
      `SMD_PAGE_2: res = {bits[5], bits[4]};
      default: res = {bits[7], bits[6]};
    endcase
    return res;
  endfunction

  // Matches one I/O port group on address bits 7 down to 3.
  function automatic logic io_hit(input logic [15:0] addr,
                                  input logic [4:0] group);
    return addr[`SMD_IO_HI:`SMD_IO_LO] == group;
  endfunction

  smd_pkg::smd_dram_state_t dram_state;
  smd_pkg::smd_dram_state_t next_dram_state;
  logic [1:0] col_page;
  logic [1:0] next_col_page;
  logic fetch_seen;
  logic [3:0] wait_left;
  logic [3:0] next_wait_left;

  // Page and slot of the current access.
  wire [1:0] cur_page = link.addr[`SMD_PAGE_HI:`SMD_PAGE_LO];
  wire [1:0] cur_slot = page_slot(link.slot_bits, cur_page);
  wire refresh_cyc = !link.refresh_strobe_n && !link.mem_request_n;
  // Refresh also drives MEM_REQUEST_N, so memory decode must exclude it.
  wire mem_cyc = !link.mem_request_n && link.refresh_strobe_n;
  wire slot0_cyc = mem_cyc && (cur_slot == `SMD_SLOT_INTERNAL);

  // Slot and ROM decode; each page follows its own slot code.
  wire next_upper = mem_cyc && (cur_slot == `SMD_SLOT_UPPER);
  wire next_rear = mem_cyc && (cur_slot == `SMD_SLOT_REAR);
  wire next_side = mem_cyc && (cur_slot == `SMD_SLOT_SIDE);
  wire next_interp = slot0_cyc && (cur_page == `SMD_PAGE_0 ||
                                   cur_page == `SMD_PAGE_1);
  wire next_rom_lo = slot0_cyc && (cur_page == `SMD_PAGE_1);
  wire next_rom_hi = slot0_cyc && (cur_page == `SMD_PAGE_2);

  // I/O decode; an interrupt acknowledge has the fetch strobe low too.
  wire io_cyc = !link.io_request_n && link.opcode_fetch_n &&
                (!link.rd_n || !link.wr_n);
  wire next_prt = io_cyc && io_hit(link.addr, `SMD_IO_PRINTER);
  wire next_vid = io_cyc && io_hit(link.addr, `SMD_IO_VIDEO);
  wire next_snd = io_cyc && io_hit(link.addr, `SMD_IO_SOUND);
  wire next_ppi = io_cyc && io_hit(link.addr, `SMD_IO_PARALLEL);

  // DRAM is in slot 0 pages 2 and 3; refresh rows need no slot.
  wire dram_hit = slot0_cyc && (cur_page == `SMD_PAGE_2 ||
                                cur_page == `SMD_PAGE_3);
  wire in_col = next_dram_state == smd_pkg::SMD_DR_COL;
  wire next_ras_n = next_dram_state == smd_pkg::SMD_DR_IDLE;
  wire next_cas_mid = in_col && next_col_page == `SMD_PAGE_2;
  wire next_cas_top = in_col && next_col_page == `SMD_PAGE_3;
  wire next_we_n = !(in_col && !link.wr_n);

  // Row, then column, held until the request ends. A refresh stays in the
  // row phase, so it is RAS-only and never moves the mux or a column strobe.
  always_comb
  begin
    next_dram_state = dram_state;
    next_col_page = col_page;
    case (dram_state)
      smd_pkg::SMD_DR_IDLE:
      begin
        if (dram_hit || refresh_cyc)
        begin
          next_dram_state = smd_pkg::SMD_DR_ROW;
          next_col_page = refresh_cyc ? `SMD_PAGE_0 : cur_page;
        end
      end
      smd_pkg::SMD_DR_ROW:
      begin
        if (link.mem_request_n)
          next_dram_state = smd_pkg::SMD_DR_IDLE;
        else if (!refresh_cyc)
          next_dram_state = smd_pkg::SMD_DR_COL;
      end
      smd_pkg::SMD_DR_COL:
      begin
        if (link.mem_request_n)
          next_dram_state = smd_pkg::SMD_DR_IDLE;
      end
      default:
        next_dram_state = smd_pkg::SMD_DR_IDLE;
    endcase
  end

  // One fetch start per fetch-strobe pulse loads the wait counter.
  wire fetch_start = !link.opcode_fetch_n && !link.mem_request_n &&
                     !fetch_seen;
  assign next_wait_left = fetch_start ? FETCH_WAITS :
                          (wait_left != 4'h0) ? wait_left - 4'h1 : 4'h0;

  // Fetch tracking and wait generation; the CPU holds while this is low.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      fetch_seen <= 1'b0;
      wait_left <= 4'h0;
      link.wait_n <= 1'b1;
    end
    else
    begin
      fetch_seen <= !link.opcode_fetch_n;
      wait_left <= next_wait_left;
      link.wait_n <= next_wait_left == 4'h0;
    end
  end

  // Interrupt line; the CPU runs it in mode 1, so no vector is supplied.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      link.cpu_irq_n <= 1'b1;
    else
      link.cpu_irq_n <= !(i_video_irq || i_cartridge_irq);
  end

  // DRAM sequencer state.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      dram_state <= smd_pkg::SMD_DR_IDLE;
      col_page <= `SMD_PAGE_0;
    end
    else
    begin
      dram_state <= next_dram_state;
      col_page <= next_col_page;
    end
  end

  // Memory-side selects, registered so every output comes from a flop.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_upper_slot_sel_n <= 1'b1;
      o_rear_slot_sel_n <= 1'b1;
      o_side_slot_sel_n <= 1'b1;
      o_interp_rom_sel_n <= 1'b1;
      o_rom_lo_page_sel_n <= 1'b1;
      o_rom_hi_page_sel_n <= 1'b1;
    end
    else
    begin
      o_upper_slot_sel_n <= !next_upper;
      o_rear_slot_sel_n <= !next_rear;
      o_side_slot_sel_n <= !next_side;
      o_interp_rom_sel_n <= !next_interp;
      o_rom_lo_page_sel_n <= !next_rom_lo;
      o_rom_hi_page_sel_n <= !next_rom_hi;
    end
  end

  // I/O selects; sound is the only active-high one.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_printer_port_sel_n <= 1'b1;
      o_video_port_sel_n <= 1'b1;
      o_sound_port_sel <= 1'b0;
      o_parallel_port_sel_n <= 1'b1;
    end
    else
    begin
      o_printer_port_sel_n <= !next_prt;
      o_video_port_sel_n <= !next_vid;
      o_sound_port_sel <= next_snd;
      o_parallel_port_sel_n <= !next_ppi;
    end
  end

  // DRAM strobes follow the next sequencer state.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_dram_row_strobe_n <= 1'b1;
      o_dram_col_strobe_bank_hi_mid_n <= 1'b1;
      o_dram_col_strobe_bank_top_n <= 1'b1;
      o_dram_addr_mux_sel <= 1'b0;
      o_dram_write_en_n <= 1'b1;
    end
    else
    begin
      o_dram_row_strobe_n <= next_ras_n;
      o_dram_col_strobe_bank_hi_mid_n <= !next_cas_mid;
      o_dram_col_strobe_bank_top_n <= !next_cas_top;
      o_dram_addr_mux_sel <= in_col;
      o_dram_write_en_n <= next_we_n;
    end
  end

endmodule

// ### hw/smd_map.svh
// Constants for the slot, memory and I/O decoder and its CPU-side end.
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH

// Address fields picked out of the CPU address bus.
`define SMD_PAGE_HI 15
`define SMD_PAGE_LO 14
`define SMD_IO_HI 7
`define SMD_IO_LO 3
`define SMD_REFRESH_STROBE_N_BITS 7

// Pages of the 64 KB memory map.
`define SMD_PAGE_0 2'h0
`define SMD_PAGE_1 2'h1
`define SMD_PAGE_2 2'h2
`define SMD_PAGE_3 2'h3

// Primary slot codes.
`define SMD_SLOT_INTERNAL 2'h0
`define SMD_SLOT_UPPER 2'h1
`define SMD_SLOT_REAR 2'h2
`define SMD_SLOT_SIDE 2'h3

// I/O port groups, matched on address bits 7 down to 3.
`define SMD_IO_PRINTER 5'h12
`define SMD_IO_VIDEO 5'h13
`define SMD_IO_SOUND 5'h14
`define SMD_IO_PARALLEL 5'h15

// Wait states added to each opcode fetch.
`define SMD_FETCH_WAITS 4'h1

// Register map of the CPU-side end, byte addresses.
`define SMD_REG_ADDR 4'h0
`define SMD_REG_SLOT 4'h4
`define SMD_REG_CMD 4'h8
`define SMD_REG_STATUS 4'hc

// Bus cycle kinds written to the command register.
`define SMD_KIND_MEM_RD 3'h0
`define SMD_KIND_MEM_WR 3'h1
`define SMD_KIND_IO_RD 3'h2
`define SMD_KIND_IO_WR 3'h3
`define SMD_KIND_FETCH 3'h4

// Reset values.
`define SMD_ADDR_RST 16'h0000
`define SMD_SLOT_RST 8'h00
`define SMD_REFRESH_STROBE_N_RST 7'h00

`endif

// ### hw/smd_pkg.sv
// Types shared by the decoder and its CPU-side end.
package smd_pkg;

  typedef enum logic [1:0] {
    SMD_DR_IDLE = 2'h0,
    SMD_DR_ROW = 2'h1,
    SMD_DR_COL = 2'h3
  } smd_dram_state_t;

  typedef enum logic [2:0] {
    SMD_CY_IDLE = 3'h0,
    SMD_CY_T1 = 3'h1,
    SMD_CY_T2 = 3'h3,
    SMD_CY_TW = 3'h7,
    SMD_CY_T3 = 3'h6,
    SMD_CY_RF = 3'h4
  } smd_cpu_state_t;

endpackage

// ### hw/smd_link_if.sv
// CPU bus link between the CPU-side end and the decoder.
`timescale 1ns/1ps
interface smd_link_if;
  logic [15:0] addr;
  logic mem_request_n;
  logic io_request_n;
  logic rd_n;
  logic wr_n;
  logic opcode_fetch_n;
  logic refresh_strobe_n;
  logic [7:0] slot_bits;
  logic wait_n;
  logic cpu_irq_n;

  modport dev (
    input addr, mem_request_n, io_request_n, rd_n, wr_n,
    input opcode_fetch_n, refresh_strobe_n, slot_bits,
    output wait_n, cpu_irq_n
  );

  modport cpu (
    output addr, mem_request_n, io_request_n, rd_n, wr_n,
    output opcode_fetch_n, refresh_strobe_n, slot_bits,
    input wait_n, cpu_irq_n
  );
endinterface

// ### hw/smd_cpu_end.sv
// CPU-side end: runs bus cycles on the link as ordered over Avalon-MM.
`timescale 1ns/1ps
`include "smd_map.svh"

module smd_cpu_end (
  input wire logic i_clk,
  input wire logic i_rstn,
  smd_link_if.cpu link,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest
);

  smd_pkg::smd_cpu_state_t state;
  logic [15:0] addr_reg;
  logic [2:0] kind;
  logic [6:0] refresh_strobe_n_row;
  logic [7:0] wait_count;

  wire busy = state != smd_pkg::SMD_CY_IDLE;
  wire req = i_read || i_write;
  wire take_wr = i_write && !o_waitrequest;
  wire start = take_wr && i_address == `SMD_REG_CMD && !busy;
  wire is_fetch = kind == `SMD_KIND_FETCH;
  wire is_io = kind == `SMD_KIND_IO_RD || kind == `SMD_KIND_IO_WR;
  wire is_wr = kind == `SMD_KIND_MEM_WR || kind == `SMD_KIND_IO_WR;
  wire [31:0] status = {16'h0000, wait_count, 6'h00, !link.cpu_irq_n, busy};
  wire [31:0] rd_mux =
    (i_address == `SMD_REG_ADDR) ? {16'h0000, addr_reg} :
    (i_address == `SMD_REG_SLOT) ? {24'h000000, link.slot_bits} :
    (i_address == `SMD_REG_STATUS) ? status : 32'h00000000;

  // One wait cycle per access: waitrequest drops for exactly one edge.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end
    else
    begin
      o_waitrequest <= !(req && o_waitrequest);
      if (i_read && o_waitrequest)
        o_readdata <= rd_mux;
    end
  end

  // Address and slot registers; the slot bits feed the decoder directly.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      addr_reg <= `SMD_ADDR_RST;
      link.slot_bits <= `SMD_SLOT_RST;
      kind <= `SMD_KIND_MEM_RD;
    end
    else
    begin
      if (take_wr && i_address == `SMD_REG_ADDR && !busy)
        addr_reg <= i_writedata[15:0];
      if (take_wr && i_address == `SMD_REG_SLOT)
        link.slot_bits <= i_writedata[7:0];
      if (start)
        kind <= i_writedata[2:0];
    end
  end

  // Cycle sequencer. A command while busy is dropped; status shows busy.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state <= smd_pkg::SMD_CY_IDLE;
      refresh_strobe_n_row <= `SMD_REFRESH_STROBE_N_RST;
      wait_count <= 8'h00;
      link.addr <= `SMD_ADDR_RST;
      link.mem_request_n <= 1'b1;
      link.io_request_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.opcode_fetch_n <= 1'b1;
      link.refresh_strobe_n <= 1'b1;
    end
    else
    begin
      case (state)
        smd_pkg::SMD_CY_IDLE:
        begin
          if (start)
          begin
            state <= smd_pkg::SMD_CY_T1;
            wait_count <= 8'h00;
            link.addr <= addr_reg;
          end
        end
        smd_pkg::SMD_CY_T1:
        begin
          state <= smd_pkg::SMD_CY_T2;
          link.opcode_fetch_n <= !is_fetch;
          link.mem_request_n <= is_io;
          link.io_request_n <= !is_io;
          link.rd_n <= is_wr;
          link.wr_n <= !is_wr;
        end
        smd_pkg::SMD_CY_T2:
          state <= smd_pkg::SMD_CY_TW;
        smd_pkg::SMD_CY_TW:
        begin
          if (link.wait_n)
            state <= smd_pkg::SMD_CY_T3;
          else
            wait_count <= wait_count + 8'h01;
        end
        smd_pkg::SMD_CY_T3:
        begin
          link.mem_request_n <= 1'b1;
          link.io_request_n <= 1'b1;
          link.rd_n <= 1'b1;
          link.wr_n <= 1'b1;
          link.opcode_fetch_n <= 1'b1;
          if (is_fetch)
            state <= smd_pkg::SMD_CY_RF;
          else
            state <= smd_pkg::SMD_CY_IDLE;
        end
        // The request lets go for one cycle before refresh; without that
        // gap the decoder would keep its column strobe low into refresh.
        smd_pkg::SMD_CY_RF:
        begin
          if (link.refresh_strobe_n)
          begin
            link.addr <= {9'h000, refresh_strobe_n_row};
            link.refresh_strobe_n <= 1'b0;
            link.mem_request_n <= 1'b0;
          end
          else
          begin
            state <= smd_pkg::SMD_CY_IDLE;
            refresh_strobe_n_row <= refresh_strobe_n_row + 7'h01;
            link.refresh_strobe_n <= 1'b1;
            link.mem_request_n <= 1'b1;
          end
        end
        default:
          state <= smd_pkg::SMD_CY_IDLE;
      endcase
    end
  end

endmodule

// ### bench/smd_link_monitor.sv
// Concurrent checks on the CPU bus link joining the two ends.
`timescale 1ns/1ps
module smd_link_monitor (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] addr,
  input wire logic mem_request_n,
  input wire logic io_request_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic opcode_fetch_n,
  input wire logic refresh_strobe_n,
  input wire logic [7:0] slot_bits,
  input wire logic wait_n,
  input wire logic cpu_irq_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // A fetch starts when its strobe falls together with the memory request.
  sequence s_fetch_start;
    $fell(opcode_fetch_n) && !mem_request_n;
  endsequence

  // Exactly one low cycle on the wait line, then it lets go.
  sequence s_one_wait;
    !wait_n ##1 wait_n;
  endsequence

  a_fetch_one_wait: assert property (s_fetch_start |=> s_one_wait)
    else $error("fetch wait not exactly one cycle");
  a_wait_only_fetch: assert property (
    !wait_n |-> !opcode_fetch_n)
    else $error("wait asserted outside a fetch");
  a_cpu_holds_wait: assert property (
    !wait_n |=> !opcode_fetch_n && !mem_request_n)
    else $error("cpu left the cycle while waiting");
  a_no_refresh_wait: assert property (!wait_n |-> refresh_strobe_n)
    else $error("refresh during a wait state");
  a_fetch_pulse: assert property (
    $fell(opcode_fetch_n) |-> ##[1:8] opcode_fetch_n)
    else $error("fetch strobe pulse too long");
  a_refresh_follows: assert property (
    $rose(opcode_fetch_n) |-> ##[0:2] !refresh_strobe_n)
    else $error("no refresh after a fetch");
  a_refresh_row: assert property (
    !refresh_strobe_n |-> addr[15:7] == 9'h000 && !mem_request_n &&
    rd_n && wr_n)
    else $error("refresh address or strobes wrong");
  a_refresh_single: assert property (
    $fell(refresh_strobe_n) |=> refresh_strobe_n)
    else $error("refresh strobe longer than one cycle");
  // The request idles a cycle before refresh, so refresh stays row-only.
  a_refresh_gap: assert property (
    $fell(refresh_strobe_n) |-> $past(mem_request_n))
    else $error("no request gap before refresh");
  a_io_not_mem: assert property (!io_request_n |-> mem_request_n)
    else $error("io and memory request together");
  a_reset_idle: assert property (
    disable iff (1'b0) !i_rstn |=> wait_n && cpu_irq_n &&
    mem_request_n && io_request_n && opcode_fetch_n && refresh_strobe_n)
    else $error("link not idle in reset");
endmodule

// ### bench/slot_memory_io_decoder_bench.sv
// Self-checking bench driving both ends through their user sides.
`timescale 1ns/1ps
`include "smd_map.svh"
module slot_memory_io_decoder_bench;
  logic i_clk;
  logic i_rstn;
  logic [3:0] i_address;
  logic i_read;
  logic i_write;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic i_video_irq;
  logic i_cartridge_irq;
  logic [14:0] outs;
  logic [14:0] seen;
  logic clr;
  logic [31:0] rd;
  int n_fail;
  int comparisons;
  // Outputs turned to active-high; the sound select and the address mux select are the only high ones.
  wire [14:0] act = outs ^ 15'h7fbd;

  smd_link_if link ();
  smd_cpu_end i_smd_cpu_end (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest));
  smd_decoder i_smd_decoder (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
    .i_video_irq(i_video_irq), .i_cartridge_irq(i_cartridge_irq),
    .o_upper_slot_sel_n(outs[14]), .o_rear_slot_sel_n(outs[13]),
    .o_side_slot_sel_n(outs[12]), .o_interp_rom_sel_n(outs[11]),
    .o_rom_lo_page_sel_n(outs[10]), .o_rom_hi_page_sel_n(outs[9]),
    .o_printer_port_sel_n(outs[8]), .o_video_port_sel_n(outs[7]),
    .o_sound_port_sel(outs[6]), .o_parallel_port_sel_n(outs[5]),
    .o_dram_row_strobe_n(outs[4]), .o_dram_col_strobe_bank_hi_mid_n(outs[3]),
    .o_dram_col_strobe_bank_top_n(outs[2]), .o_dram_addr_mux_sel(outs[1]),
    .o_dram_write_en_n(outs[0]));
  smd_link_monitor i_smd_link_monitor (.i_clk(i_clk), .i_rstn(i_rstn),
    .addr(link.addr), .mem_request_n(link.mem_request_n),
    .io_request_n(link.io_request_n), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .opcode_fetch_n(link.opcode_fetch_n),
    .refresh_strobe_n(link.refresh_strobe_n), .slot_bits(link.slot_bits),
    .wait_n(link.wait_n), .cpu_irq_n(link.cpu_irq_n));

  // The clock toggles every 10 ns for a 20 ns period.
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Every output that went active during a cycle is remembered here.
  always @(posedge i_clk)
    seen <= clr ? 15'h0000 : (seen | act);

  task summarize();
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task cmp_mask(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // Avalon requests are held until waitrequest is sampled low.
  task av_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= 1'b1;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
  endtask

  task av_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_read <= 1'b1;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    d = o_readdata;
    i_read <= 1'b0;
  endtask

  // Expected active outputs of one bus cycle, refresh included.
  function automatic logic [14:0] exp_mask(input logic [2:0] k,
    input logic [15:0] a, input logic [7:0] s);
    logic [1:0] p;
    logic [1:0] c;
    logic mem;
    logic io;
    logic hit;
    logic [14:0] m;
    p = a[15:14];
    c = s[{p, 1'b0} +: 2];
    mem = k == `SMD_KIND_MEM_RD || k == `SMD_KIND_MEM_WR
      || k == `SMD_KIND_FETCH;
    io = k == `SMD_KIND_IO_RD || k == `SMD_KIND_IO_WR;
    hit = mem && c == `SMD_SLOT_INTERNAL && p[1];
    m[14] = mem && c == `SMD_SLOT_UPPER;
    m[13] = mem && c == `SMD_SLOT_REAR;
    m[12] = mem && c == `SMD_SLOT_SIDE;
    m[11] = mem && c == `SMD_SLOT_INTERNAL && !p[1];
    m[10] = mem && c == `SMD_SLOT_INTERNAL && p == `SMD_PAGE_1;
    m[9] = mem && c == `SMD_SLOT_INTERNAL && p == `SMD_PAGE_2;
    m[8] = io && a[7:3] == `SMD_IO_PRINTER;
    m[7] = io && a[7:3] == `SMD_IO_VIDEO;
    m[6] = io && a[7:3] == `SMD_IO_SOUND;
    m[5] = io && a[7:3] == `SMD_IO_PARALLEL;
    m[4] = hit || k == `SMD_KIND_FETCH;
    m[3] = hit && p == `SMD_PAGE_2;
    m[2] = hit && p == `SMD_PAGE_3;
    m[1] = hit;
    m[0] = hit && k == `SMD_KIND_MEM_WR;
    return m;
  endfunction

  // Runs one link cycle, then checks the outputs seen and the wait count.
  task chk(input logic [2:0] k, input logic [15:0] a, input logic [7:0] s);
    av_write(`SMD_REG_ADDR, {16'h0000, a});
    av_write(`SMD_REG_SLOT, {24'h000000, s});
    @(posedge i_clk);
    clr <= 1'b1;
    av_write(`SMD_REG_CMD, {29'h0, k});
    clr <= 1'b0;
    do av_read(`SMD_REG_STATUS, rd); while (rd[0] !== 1'b0);
    repeat (2) @(posedge i_clk);
    cmp_mask(seen, exp_mask(k, a, s));
    cmp_word({24'h0, rd[15:8]},
      (k == `SMD_KIND_FETCH) ? {28'h0, `SMD_FETCH_WAITS} : 32'h0);
    cmp_mask(act, 15'h0000);
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    summarize();
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    i_rstn = 1'b0;
    i_address = 4'h0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    i_video_irq = 1'b0;
    i_cartridge_irq = 1'b0;
    clr = 1'b1;
    repeat (20) @(posedge i_clk);
    cmp_mask(act, 15'h0000);
    i_rstn <= 1'b1;
    av_write(`SMD_REG_ADDR, 32'h0000abcd);
    av_read(`SMD_REG_ADDR, rd);
    cmp_word(rd, 32'h0000abcd);
    av_read(4'h1, rd);
    cmp_word(rd, 32'h0);
    chk(`SMD_KIND_MEM_RD, 16'h8000, 8'h00);
    chk(`SMD_KIND_MEM_WR, 16'hc123, 8'h00);
    chk(`SMD_KIND_FETCH, 16'h8000, 8'h00);
    chk(`SMD_KIND_FETCH, 16'h4000, 8'he4);
    chk(`SMD_KIND_MEM_RD, 16'h4000, 8'h00);
    chk(`SMD_KIND_MEM_RD, 16'h0010, 8'h00);
    chk(`SMD_KIND_MEM_RD, 16'h8000, 8'he4);
    chk(`SMD_KIND_MEM_WR, 16'hffff, 8'he4);
    chk(`SMD_KIND_MEM_WR, 16'hc000, 8'h3f);
    chk(`SMD_KIND_MEM_RD, 16'h7fff, 8'h3f);
    chk(`SMD_KIND_IO_RD, 16'h0090, 8'h00);
    chk(`SMD_KIND_IO_WR, 16'h009f, 8'h00);
    chk(`SMD_KIND_IO_RD, 16'h00a0, 8'h00);
    chk(`SMD_KIND_IO_WR, 16'h00af, 8'h00);
    chk(`SMD_KIND_IO_RD, 16'h00b7, 8'h00);
    i_video_irq <= 1'b1;
    av_read(`SMD_REG_STATUS, rd);
    cmp_word({31'h0, rd[1]}, 32'h1);
    i_video_irq <= 1'b0;
    i_cartridge_irq <= 1'b1;
    av_read(`SMD_REG_STATUS, rd);
    cmp_word({31'h0, rd[1]}, 32'h1);
    i_cartridge_irq <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp_word({31'h0, link.cpu_irq_n}, 32'h1);
    // A reset in the middle of a fetch must drop every output within three edges.
    av_write(`SMD_REG_CMD, {29'h0, `SMD_KIND_FETCH});
    // Two edges on, the strobes are low and the wait line is pulled.
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp_mask(act, 15'h0000);
    cmp_word({31'h0, link.wait_n}, 32'h1);
    i_rstn <= 1'b1;
    chk(`SMD_KIND_FETCH, 16'hc000, 8'h00);
    summarize();
  end
endmodule
